// >>> rtl/tcg_dev.sv
// device end: control registers and parameter memory gateway
// assumes the host end holds req until ack and drives it on CLK
//
// Notes on behaviour
// [RULE1] host writes zeros into mode bits 7:3
// [RULE2] mode upper bits read meaningless, host ignores
// [RULE3] bit 2 starts compensation, reads busy
// [RULE4] bits 1:0 select active, doze, sleep
// [RULE5] host waits irq or 300 ms after wake
// [RULE6] output bits switch on or off level
// [RULE7] bits of non-output pins are ignored
// [RULE8] output control loads power-up state parameter
// [RULE9] pin selector picks dimmable pin zero-seven
// [RULE10] intensity register reads and writes selected pin
// [RULE11] intensities start at on or off level
// [RULE12] 0xDE then 0x00 resets the chip
// [RULE13] gateway enable 01 on, 00 off
// [RULE14] direction bit: 0 write, 1 read
// [RULE15] base is multiple of eight, max 0x78
// [RULE16] every burst moves exactly eight bytes
// [RULE17] high burn key must be 0x62
// [RULE18] low burn key must be 0x9D
// [RULE19] gateway bytes use addresses zero to seven
// [RULE20] writing 000 to bits 5:3 ends transfer
// [RULE21] 0xA5 then 0x5A to base starts burn
// [RULE22] committed write burst raises irq when awake
// [RULE23] reserved codes and unused addresses are ignored
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tcg_consts.svh"
module tcg_dev (
  tcg_link_if.dev LNK,
  input wire logic CLK,
  input wire logic RST,
  input wire logic COMP_DONE,
  input wire logic AUTOLIGHT,
  output logic [1:0] MODE,
  output logic COMP_BUSY,
  output logic COMP_START,
  output logic [7:0] OUT_ON,
  output logic [63:0] DIM_LEVEL,
  output logic BURN_START,
  output logic CHIP_RST
);
  // ==========================================================
  // state
  logic rst;
  logic init_r;
  logic ack_r;
  logic [7:0] rdata_r;
  logic irq_n_r;
  tcg_pkg::tcg_mode_t mode_r;
  logic comp_r;
  logic comp_start_r;
  logic [7:0] outc_r;
  logic [2:0] psel_r;
  logic [7:0] dim_r [8];
  logic [1:0] gw_en_r;
  logic gw_dir_r;
  logic [7:0] base_r;
  logic [7:0] stg_r [8];
  logic [7:0] stg_v_r;
  logic [7:0] spm_r [`TCG_SPM_DEPTH];
  logic [7:0] keyh_r;
  logic [7:0] keyl_r;
  logic burn_arm_r;
  logic burn_r;
  logic [7:0] srst_key_r;
  logic srst_arm_r;
  logic srst_r;
  logic take;
  logic wr;
  logic gw_on;
  logic gw_hit;
  logic [7:0] omask;
  logic [7:0] on_lvl;
  logic [7:0] off_lvl;
  logic outc_wr;
  logic gw_end;
  logic commit;
  logic [6:0] gw_idx;

  // write strobe for one normal register, gateway window excluded
  function automatic logic wr_to(input logic [7:0] a);
    wr_to = wr && !gw_hit && (LNK.addr == a);
  endfunction

  // ==========================================================
  // request decode
  assign rst = RST | srst_r; // soft reset acts like the pin, except on parameter memory and the soft reset key logic
  assign take = LNK.req && !ack_r && !init_r;
  assign wr = take && LNK.we;
  assign gw_on = (gw_en_r == `TCG_GW_ON);
  assign gw_hit = gw_on && (LNK.addr[7:3] == 5'h00); // [RULE19]
  assign gw_idx = base_r[6:0] + {4'h0, LNK.addr[2:0]};
  assign omask = spm_r[`TCG_SPM_OMASK];
  assign on_lvl = spm_r[`TCG_SPM_ONLVL];
  assign off_lvl = spm_r[`TCG_SPM_OFFLVL];
  assign outc_wr = wr_to(`TCG_A_OUTC) && !AUTOLIGHT; // [RULE6]
  // end of transfer: 000 into bits 5:3 while gateway is on
  assign gw_end = wr_to(`TCG_A_GCFG) && gw_on &&
                  (LNK.wdata[5:3] == 3'h0); // [RULE20]
  // write burst takes effect only with all eight bytes staged
  assign commit = gw_end && !gw_dir_r && (&stg_v_r); // [RULE16]

  // ==========================================================
  // start-up load and link answer
  always_ff @(posedge CLK) begin
    init_r <= rst; // one cycle to read parameters after reset
    ack_r <= rst ? 1'b0 : take;
  end

  // soft reset key sequence
  always_ff @(posedge CLK) begin
    if (RST) begin
      srst_r <= 1'b0;
      srst_arm_r <= 1'b0;
      srst_key_r <= `TCG_BYTE_RST;
    end else begin
      srst_r <= 1'b0;
      if (wr_to(`TCG_A_SRST)) begin
        srst_key_r <= LNK.wdata;
        srst_arm_r <= (LNK.wdata == `TCG_SRST1_VAL);
        if (srst_arm_r && LNK.wdata == `TCG_SRST2_VAL) begin
          srst_r <= 1'b1; // [RULE12]
        end
      end
    end
  end

  // operating mode and compensation
  always_ff @(posedge CLK) begin
    if (rst) begin
      mode_r <= tcg_pkg::TCG_ACTIVE;
      comp_r <= 1'b0;
      comp_start_r <= 1'b0;
    end else begin
      comp_start_r <= 1'b0;
      if (wr_to(`TCG_A_MODE) && LNK.wdata[1:0] != `TCG_MODE_RSVD) begin
        mode_r <= tcg_pkg::tcg_mode_t'(LNK.wdata[1:0]); // [RULE4] [RULE23]
      end
      // a new trigger wins over a completion in the same cycle
      if (wr_to(`TCG_A_MODE) && LNK.wdata[`TCG_COMP_BIT]) begin
        comp_r <= 1'b1; // [RULE3]
        comp_start_r <= 1'b1;
      end else if (COMP_DONE) begin
        comp_r <= 1'b0; // [RULE3]
      end
    end
  end

  // output on/off control and pin selector
  always_ff @(posedge CLK) begin
    if (rst) begin
      outc_r <= `TCG_BYTE_RST;
      psel_r <= `TCG_PSEL_RST;
    end else begin
      if (init_r) begin
        outc_r <= spm_r[`TCG_SPM_PWRUP]; // [RULE8]
      end else if (outc_wr) begin
        outc_r <= (LNK.wdata & omask) | (outc_r & ~omask); // [RULE7]
      end
      if (wr_to(`TCG_A_PSEL)) begin
        psel_r <= LNK.wdata[2:0]; // [RULE9]
      end
    end
  end

  // one intensity index per dimmable pin
  generate
    for (genvar i = 0; i < 8; i++) begin : g_dim
      always_ff @(posedge CLK) begin
        if (rst) begin
          dim_r[i] <= `TCG_BYTE_RST;
        end else if (init_r) begin
          dim_r[i] <= spm_r[`TCG_SPM_PWRUP][i] ? on_lvl : off_lvl; // [RULE11]
        end else if (wr_to(`TCG_A_INT) && psel_r == 3'(i)) begin
          dim_r[i] <= LNK.wdata; // [RULE10]
        end else if (outc_wr && omask[i]) begin
          dim_r[i] <= LNK.wdata[i] ? on_lvl : off_lvl; // [RULE6]
        end
      end
      assign DIM_LEVEL[i*8 +: 8] = dim_r[i];
    end
  endgenerate

  // gateway configuration and base address
  always_ff @(posedge CLK) begin
    if (rst) begin
      gw_en_r <= `TCG_GW_OFF;
      gw_dir_r <= 1'b0;
      base_r <= `TCG_BASE_RST;
    end else begin
      if (wr_to(`TCG_A_GCFG) &&
          (LNK.wdata[5:4] == `TCG_GW_ON || LNK.wdata[5:4] == `TCG_GW_OFF)) begin
        gw_en_r <= LNK.wdata[`TCG_GW_EN_HI:`TCG_GW_EN_LO]; // [RULE13] [RULE23]
        gw_dir_r <= LNK.wdata[`TCG_GW_DIR_BIT]; // [RULE14]
      end
      if (wr_to(`TCG_A_GBASE) && LNK.wdata[2:0] == 3'h0 &&
          LNK.wdata <= `TCG_BASE_MAX) begin
        base_r <= LNK.wdata; // [RULE15]
      end
    end
  end

  // staging of the eight burst bytes
  always_ff @(posedge CLK) begin
    if (rst || gw_end) begin
      stg_v_r <= 8'h00;
    end else if (wr && gw_hit && !gw_dir_r) begin
      stg_r[LNK.addr[2:0]] <= LNK.wdata; // [RULE19]
      stg_v_r[LNK.addr[2:0]] <= 1'b1;
    end
  end

  // parameter memory, kept across a soft reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int k = 0; k < `TCG_SPM_DEPTH; k++) begin
        spm_r[k] <= `TCG_BYTE_RST;
      end
    end else if (commit) begin
      for (int k = 0; k < `TCG_BURST_LEN; k++) begin
        spm_r[base_r[6:0] + k[6:0]] <= stg_r[k]; // [RULE16]
      end
    end
  end

  // write-done flag, cleared by reading the source address
  always_ff @(posedge CLK) begin
    if (rst) begin
      irq_n_r <= 1'b1;
    end else if (commit && mode_r != tcg_pkg::TCG_SLEEP) begin
      irq_n_r <= 1'b0; // [RULE22]
    end else if (take && !LNK.we && !gw_hit &&
                 LNK.addr == `TCG_A_INTERRUPT_SOURCE) begin
      irq_n_r <= 1'b1;
    end
  end

  // burn keys and two-step start sequence
  always_ff @(posedge CLK) begin
    if (rst) begin
      keyh_r <= `TCG_BYTE_RST;
      keyl_r <= `TCG_BYTE_RST;
      burn_arm_r <= 1'b0;
      burn_r <= 1'b0;
    end else begin
      burn_r <= 1'b0;
      if (wr_to(`TCG_A_KEYH)) begin
        keyh_r <= LNK.wdata; // [RULE17]
      end
      if (wr_to(`TCG_A_KEYL)) begin
        keyl_r <= LNK.wdata; // [RULE18]
      end
      if (wr_to(`TCG_A_GBASE)) begin
        burn_arm_r <= (LNK.wdata == `TCG_BURN1_VAL) &&
                      (keyh_r == `TCG_KEYH_VAL) &&
                      (keyl_r == `TCG_KEYL_VAL); // [RULE17] [RULE18]
        if (burn_arm_r && LNK.wdata == `TCG_BURN2_VAL) begin
          burn_r <= 1'b1; // [RULE21]
          keyh_r <= `TCG_BYTE_RST;
          keyl_r <= `TCG_BYTE_RST;
        end
      end else if (wr) begin
        burn_arm_r <= 1'b0; // any other write breaks the sequence
      end
    end
  end

  // read data, captured with the request
  always_ff @(posedge CLK) begin
    if (rst) begin
      rdata_r <= `TCG_BYTE_RST;
    end else if (take && !LNK.we) begin
      if (gw_hit) begin
        rdata_r <= gw_dir_r ? spm_r[gw_idx] : `TCG_BYTE_RST; // [RULE19]
      end else begin
        unique case (LNK.addr)
          `TCG_A_INTERRUPT_SOURCE: rdata_r <= {2'b00, !irq_n_r, 5'h00};
          `TCG_A_MODE: rdata_r <= {5'h00, comp_r, mode_r}; // [RULE2]
          `TCG_A_OUTC: rdata_r <= outc_r;
          `TCG_A_PSEL: rdata_r <= {5'h00, psel_r};
          `TCG_A_INT: rdata_r <= dim_r[psel_r]; // [RULE10]
          `TCG_A_GCFG: rdata_r <= {2'b00, gw_en_r, gw_dir_r, 3'h0};
          `TCG_A_GBASE: rdata_r <= base_r;
          `TCG_A_KEYH: rdata_r <= keyh_r;
          `TCG_A_KEYL: rdata_r <= keyl_r;
          `TCG_A_SRST: rdata_r <= srst_key_r;
          default: rdata_r <= `TCG_BYTE_RST; // [RULE23]
        endcase
      end
    end
  end

  // ==========================================================
  // outputs
  assign LNK.ack = ack_r;
  assign LNK.rdata = rdata_r;
  assign LNK.irq_n = irq_n_r;
  assign MODE = mode_r;
  assign COMP_BUSY = comp_r;
  assign COMP_START = comp_start_r;
  assign OUT_ON = outc_r;
  assign BURN_START = burn_r;
  assign CHIP_RST = srst_r;
endmodule // tcg_dev
`default_nettype wire

// >>> rtl/tcg_host.sv
// host end: turns Wishbone commands into link accesses
// assumes a classic Wishbone master on the same clock as the link
`timescale 1ns/1ps
`default_nettype none
`include "tcg_consts.svh"
module tcg_host #(
  parameter int unsigned HOLD_CYCLES = `TCG_MODE_WAIT_MS * `TCG_CLK_KHZ
) (
  tcg_link_if.host LNK,
  input wire logic CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O
);
  // ==========================================================
  // state
  tcg_pkg::tcg_hst_t st_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic req_r;
  logic we_r;
  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic refused_r;
  logic [31:0] hold_r;
  logic wb_req;
  logic go;
  logic [7:0] cmd_a;
  logic [7:0] cmd_d;
  logic base_bad;
  logic wake;

  assign wb_req = WB_CYC_I && WB_STB_I && !ack_r;
  assign go = wb_req && WB_WE_I && WB_ADR_I == `TCG_H_CMD &&
              WB_SEL_I[2:0] == 3'b111;
  assign cmd_a = WB_DAT_I[7:0];
  assign cmd_d = WB_DAT_I[15:8];
  // base values other than burn keys must be aligned and in range
  assign base_bad = WB_DAT_I[16] && cmd_a == `TCG_A_GBASE &&
                    cmd_d != `TCG_BURN1_VAL && cmd_d != `TCG_BURN2_VAL &&
                    (cmd_d[2:0] != 3'h0 || cmd_d > `TCG_BASE_MAX); // [RULE15]
  assign wake = we_r && addr_r == `TCG_A_MODE &&
                (wdata_r[1:0] == tcg_pkg::TCG_ACTIVE ||
                 wdata_r[1:0] == tcg_pkg::TCG_DOZE);

  // ==========================================================
  // Wishbone slave answer, one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      if (wb_req && !WB_WE_I) begin
        dat_r <= (WB_ADR_I == `TCG_H_STAT) ?
          {16'h0000, rdata_r, 5'h00, refused_r, !LNK.irq_n,
           st_r != tcg_pkg::TCG_HS_IDLE} : 32'h0000_0000;
      end
    end
  end

  // read hold-off after a wake-up mode write
  always_ff @(posedge CLK) begin
    if (RST || !LNK.irq_n) begin
      hold_r <= 32'h0000_0000; // [RULE5]
    end else if (st_r == tcg_pkg::TCG_HS_REQ && LNK.ack && wake) begin
      hold_r <= HOLD_CYCLES; // [RULE5]
    end else if (hold_r != 32'h0000_0000) begin
      hold_r <= hold_r - 32'h0000_0001;
    end
  end

  // command sequencer
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r <= tcg_pkg::TCG_HS_IDLE;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= `TCG_BYTE_RST;
      wdata_r <= `TCG_BYTE_RST;
      rdata_r <= `TCG_BYTE_RST;
      refused_r <= 1'b0;
    end else begin
      unique case (st_r)
        tcg_pkg::TCG_HS_IDLE: begin
          if (go && base_bad) begin
            refused_r <= 1'b1;
          end else if (go) begin
            refused_r <= 1'b0;
            we_r <= WB_DAT_I[16];
            addr_r <= cmd_a;
            // reserved mode bits always go out as zero
            wdata_r <= (cmd_a == `TCG_A_MODE) ?
                       {5'h00, cmd_d[2:0]} : cmd_d; // [RULE1]
            if (!WB_DAT_I[16] && hold_r != 32'h0000_0000) begin
              st_r <= tcg_pkg::TCG_HS_HOLD; // [RULE5]
            end else begin
              st_r <= tcg_pkg::TCG_HS_REQ;
              req_r <= 1'b1;
            end
          end
        end
        tcg_pkg::TCG_HS_HOLD: begin
          if (hold_r == 32'h0000_0000 || !LNK.irq_n) begin
            st_r <= tcg_pkg::TCG_HS_REQ; // [RULE5]
            req_r <= 1'b1;
          end
        end
        tcg_pkg::TCG_HS_REQ: begin
          if (LNK.ack) begin
            req_r <= 1'b0;
            if (!we_r) begin
              rdata_r <= LNK.rdata;
            end
            st_r <= tcg_pkg::TCG_HS_IDLE;
          end
        end
        default: st_r <= tcg_pkg::TCG_HS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;
  assign LNK.req = req_r;
  assign LNK.we = we_r;
  assign LNK.addr = addr_r;
  assign LNK.wdata = wdata_r;
endmodule // tcg_host
`default_nettype wire

// >>> shared/tcg_consts.svh
// constants of the touch controller register bank and its host end
// assumes it is included by bare name wherever a number is needed
`ifndef TCG_CONSTS_SVH
`define TCG_CONSTS_SVH
// ==========================================================
// device register offsets
`define TCG_A_INTERRUPT_SOURCE 8'h00
`define TCG_A_MODE 8'h09
`define TCG_A_OUTC 8'h0a
`define TCG_A_PSEL 8'h0b
`define TCG_A_INT 8'h0c
`define TCG_A_GCFG 8'h0d
`define TCG_A_GBASE 8'h0e
`define TCG_A_KEYH 8'hac
`define TCG_A_KEYL 8'had
`define TCG_A_SRST 8'hb1
// ==========================================================
// field positions and encodings
`define TCG_COMP_BIT 2
`define TCG_MODE_RSVD 2'b11
`define TCG_GW_EN_HI 5
`define TCG_GW_EN_LO 4
`define TCG_GW_DIR_BIT 3
`define TCG_GW_ON 2'b01
`define TCG_GW_OFF 2'b00
`define TCG_IRQ_SPMW_BIT 5
`define TCG_BASE_MAX 8'h78
`define TCG_BURST_LEN 8
`define TCG_SPM_DEPTH 128
// ==========================================================
// key values
`define TCG_KEYH_VAL 8'h62
`define TCG_KEYL_VAL 8'h9d
`define TCG_BURN1_VAL 8'ha5
`define TCG_BURN2_VAL 8'h5a
`define TCG_SRST1_VAL 8'hde
`define TCG_SRST2_VAL 8'h00
// ==========================================================
// parameter memory locations read at start-up or on output control writes
`define TCG_SPM_PWRUP 7'h60
`define TCG_SPM_ONLVL 7'h61
`define TCG_SPM_OFFLVL 7'h62
`define TCG_SPM_OMASK 7'h63
// ==========================================================
// reset values
`define TCG_BASE_RST 8'h00
`define TCG_PSEL_RST 3'h0
`define TCG_BYTE_RST 8'h00
// ==========================================================
// host register offsets and timing
`define TCG_H_CMD 8'h00
`define TCG_H_STAT 8'h04
`define TCG_MODE_WAIT_MS 300
`define TCG_CLK_KHZ 10000
`endif

// >>> shared/tcg_link_if.sv
// register access link between host end and device end
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface tcg_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic irq_n;
  modport dev (input req, input we, input addr, input wdata,
               output ack, output rdata, output irq_n);
  modport host (output req, output we, output addr, output wdata,
                input ack, input rdata, input irq_n);
endinterface
`default_nettype wire

// >>> shared/tcg_pkg.sv
// types shared by both ends of the touch controller link
// assumes nothing beyond a SystemVerilog compiler
package tcg_pkg;
  typedef enum logic [1:0] {
    TCG_ACTIVE = 2'b00,
    TCG_DOZE = 2'b01,
    TCG_SLEEP = 2'b10
  } tcg_mode_t;
  typedef enum logic [1:0] {
    TCG_HS_IDLE = 2'b00,
    TCG_HS_HOLD = 2'b01,
    TCG_HS_REQ = 2'b10
  } tcg_hst_t;
endpackage

// >>> sim/tb_touch_ctrl_param_gateway_regs.sv
// bench: host end and device end joined by the link, with checker
// assumes the design files, the link interface and the checker
`timescale 1ns/1ps
`default_nettype none
module tb_touch_ctrl_param_gateway_regs;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic comp_done = 1'h0;
  logic autolight = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic wen = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o, busy_c, burn, comp_go, chip_rst;
  logic [1:0] mode;
  logic [7:0] out_on;
  logic [63:0] dim;
  int num_errors = 0;
  int num_checks = 0;
  int burns = 0;
  int starts = 0;
  int chips = 0;
  int ticks = 0;
  tcg_link_if lnk ();
  tcg_dev tcg_dev_inst (.LNK(lnk.dev), .CLK(clk), .RST(rst),
    .COMP_DONE(comp_done), .AUTOLIGHT(autolight), .MODE(mode),
    .COMP_BUSY(busy_c), .COMP_START(comp_go), .OUT_ON(out_on),
    .DIM_LEVEL(dim), .BURN_START(burn), .CHIP_RST(chip_rst));
  tcg_host #(.HOLD_CYCLES(50)) tcg_host_inst (.LNK(lnk.host), .CLK(clk),
    .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wen),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack_o));
  tcg_link_monitor tcg_link_monitor_inst (.CLK(clk), .RST(rst),
    .req(lnk.req), .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata),
    .ack(lnk.ack), .rdata(lnk.rdata), .irq_n(lnk.irq_n));
  // ==========================================================
  // clock, burn pulse count and hang limit
  always #50 clk = ~clk;
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (burn === 1'h1)
      burns <= burns + 1;
    if (comp_go === 1'h1)
      starts <= starts + 1;
    if (chip_rst === 1'h1)
      chips <= chips + 1;
    if (ticks == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] got,
                     input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'h1;
    stb <= 1'h1;
    wen <= w;
    adr <= a;
    dat <= d;
    // ack_o ends this wait, one cycle after the strobe
    do begin
      @(posedge clk);
    end while (ack_o !== 1'h1);
    q = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  // one link access: command, then poll status until idle
  task automatic lk(input logic w, input logic [7:0] a,
                    input logic [7:0] d, output logic [7:0] q);
    logic [31:0] s;
    wb(1'h1, 8'h00, {15'h0000, w, d, a}, s);
    do begin
      wb(1'h0, 8'h04, 32'h0000_0000, s);
    end while (s[0] !== 1'h0);
    q = s[15:8];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    lk(1'h1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [7:0] e);
    logic [7:0] q;
    lk(1'h0, a, 8'h00, q);
    chk(nm, q, e);
  endtask
  // ==========================================================
  // burst write, burst read back, then soft reset reload
  task automatic t_gateway();
    logic [7:0] b [8];
    logic [31:0] s;
    logic [63:0] lv;
    int i;
    b = '{8'h05, 8'hc3, 8'h1e, 8'h0f, 8'h44, 8'h45, 8'h46, 8'h47};
    rdc("psel_rst", 8'h0b, 8'h00);
    rdc("gcfg_rst", 8'h0d, 8'h00);
    wr(8'h0d, 8'h10);
    wr(8'h0e, 8'h60);
    for (i = 0; i < 8; i++) begin
      wr(i[7:0], b[i]);
    end
    rdc("gw_wdir", 8'h00, 8'h00);
    wr(8'h0d, 8'h00);
    wb(1'h0, 8'h04, 32'h0000_0000, s);
    chk("irq_set", s[1], 1'h1);
    rdc("irq_src", 8'h00, 8'h20);
    wb(1'h0, 8'h04, 32'h0000_0000, s);
    chk("irq_clr", s[1], 1'h0);
    wr(8'h0d, 8'h18);
    wr(8'h0e, 8'h60);
    for (i = 0; i < 8; i++) begin
      rdc("gw_rd", i[7:0], b[i]);
    end
    wr(8'h0d, 8'h00);
    wb(1'h0, 8'h04, 32'h0000_0000, s);
    chk("irq_rd", s[1], 1'h0);
    wr(8'hb1, 8'hde);
    wr(8'hb1, 8'h00);
    chk("chip_rst", chips, 1);
    rdc("base_rst", 8'h0e, 8'h00);
    chk("out_load", out_on, 8'h05);
    for (i = 0; i < 8; i++) begin
      lv[8*i +: 8] = b[0][i] ? 8'hc3 : 8'h1e;
    end
    chk("dim_load", dim, lv);
  endtask
  // every mode, a reserved code, compensation start and finish
  task automatic t_mode();
    logic [1:0] m [4];
    int i;
    m = '{2'h1, 2'h0, 2'h2, 2'h2};
    for (i = 0; i < 4; i++) begin
      wr(8'h09, {6'h00, (i == 3) ? 2'h3 : m[i]});
      chk("mode", mode, m[i]);
      rdc("mode_rd", 8'h09, {6'h00, m[i]});
    end
    wr(8'h09, 8'h06);
    chk("comp_busy", busy_c, 1'h1);
    chk("comp_start", starts, 1);
    rdc("comp_rd", 8'h09, 8'h06);
    comp_done <= 1'h1;
    @(posedge clk);
    comp_done <= 1'h0;
    rdc("comp_end", 8'h09, 8'h02);
  endtask
  // output control, automatic lighting, per pin intensity
  task automatic t_outputs();
    int i;
    wr(8'h0a, 8'hff);
    chk("out_on", out_on, 8'h0f);
    chk("dim_on", dim, 64'h1e1e_1e1e_c3c3_c3c3);
    autolight <= 1'h1;
    wr(8'h0a, 8'h00);
    chk("out_auto", out_on, 8'h0f);
    autolight <= 1'h0;
    wr(8'h0a, 8'h00);
    chk("out_off", out_on, 8'h00);
    chk("dim_off", dim, 64'h1e1e_1e1e_1e1e_1e1e);
    for (i = 0; i < 8; i++) begin
      wr(8'h0b, i[7:0]);
      wr(8'h0c, 8'hf8 + i[7:0]);
    end
    for (i = 7; i >= 0; i--) begin
      wr(8'h0b, i[7:0]);
      rdc("int_rd", 8'h0c, 8'hf8 + i[7:0]);
    end
    chk("dim_all", dim, 64'hfffe_fdfc_fbfa_f9f8);
  endtask
  // base limits, refused base, burn keys right and wrong
  task automatic t_burn();
    logic [31:0] s;
    int n;
    wr(8'h0e, 8'h78);
    rdc("base_max", 8'h0e, 8'h78);
    wb(1'h1, 8'h00, {15'h0000, 1'h1, 8'h41, 8'h0e}, s);
    wb(1'h0, 8'h04, 32'h0000_0000, s);
    chk("refused", s[2], 1'h1);
    rdc("base_kept", 8'h0e, 8'h78);
    wr(8'h0d, 8'h20);
    rdc("gcfg_rsvd", 8'h0d, 8'h00);
    wr(8'h0f, 8'h55);
    rdc("unused", 8'h0f, 8'h00);
    n = burns;
    wr(8'hac, 8'h62);
    wr(8'had, 8'h9d);
    wr(8'h0e, 8'ha5);
    wr(8'h0e, 8'h5a);
    chk("burn", burns - n, 1);
    wr(8'hac, 8'h63);
    wr(8'had, 8'h9d);
    wr(8'h0e, 8'ha5);
    wr(8'h0e, 8'h5a);
    chk("no_burn", burns - n, 1);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_gateway();
    t_mode();
    t_outputs();
    t_burn();
    report_and_stop();
  end
endmodule // tb_touch_ctrl_param_gateway_regs
`default_nettype wire

// >>> sim/tcg_link_monitor.sv
// checker of the link between host end and device end
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module tcg_link_monitor (
  input wire logic CLK,
  input wire logic RST,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic irq_n
);
  // ==========================================================
  // shadows of what the host has written
  logic tk, rda, srst, arm_r, gw_r, gwrd_r;
  logic [1:0] mode_r;
  logic [2:0] psel_r;
  logic [3:0] end_r;
  assign tk = req && !ack;
  assign rda = ack && !we;
  assign srst = tk && we && addr == 8'hb1 && wdata == 8'h00 && arm_r;
  // register copies, cleared by either reset
  always_ff @(posedge CLK) begin
    if (RST || srst) begin
      mode_r <= 2'h0;
      psel_r <= 3'h0;
      gw_r <= 1'h0;
      gwrd_r <= 1'h0;
    end else if (tk && we) begin
      if (addr == 8'h09 && wdata[1:0] != 2'h3)
        mode_r <= wdata[1:0];
      if (addr == 8'h0b)
        psel_r <= wdata[2:0];
      if (addr == 8'h0d && wdata[5:4] == 2'h1) begin
        gw_r <= 1'h1;
        gwrd_r <= wdata[3];
      end
      if (addr == 8'h0d && wdata[5:4] == 2'h0)
        gw_r <= 1'h0;
    end
  end
  // first half of the soft reset key seen
  always_ff @(posedge CLK) begin
    if (RST)
      arm_r <= 1'h0;
    else if (tk && we && addr == 8'hb1)
      arm_r <= (wdata == 8'hde);
  end
  // cycles since the host ended a gateway transfer
  always_ff @(posedge CLK) begin
    if (RST)
      end_r <= 4'hf;
    else if (tk && we && addr == 8'h0d && wdata[5:3] == 3'h0)
      end_r <= 4'h0;
    else if (end_r != 4'hf)
      end_r <= end_r + 4'h1;
  end
  // ==========================================================
  // properties
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence s_irq_read;
    tk && !we && addr == 8'h00 && !gw_r && !irq_n;
  endsequence
  sequence s_flag_then_clear;
    ##1 (ack && rdata[5]) ##[0:1] irq_n;
  endsequence
  AST_MODE_READBACK:
    assert property (rda && addr == 8'h09 |-> rdata[1:0] == mode_r)
      else $error("mode field differs from last legal write");
  AST_PSEL_READBACK:
    assert property (rda && addr == 8'h0b |-> rdata == {5'h00, psel_r})
      else $error("pin selector read wrong");
  AST_BASE_ALIGNED:
    assert property (rda && addr == 8'h0e |-> rdata[2:0] == 3'h0
      && rdata <= 8'h78) else $error("base address out of range");
  AST_GW_WDIR_ZERO:
    assert property (rda && addr < 8'h08 && gw_r && !gwrd_r
      |-> rdata == 8'h00) else $error("write gateway read not zero");
  AST_IRQ_CAUSE:
    assert property ($fell(irq_n) |-> end_r <= 4'h8)
      else $error("irq without ended write burst");
  AST_IRQ_CLEAR:
    assert property (s_irq_read |-> s_flag_then_clear)
      else $error("source read did not flag and clear irq");
  AST_ACK_TIMELY:
    assert property (tk |-> ##[1:2] ack)
      else $error("link request not answered");
  AST_ACK_PULSE:
    assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
endmodule // tcg_link_monitor
`default_nettype wire
